// file: sim/facd_array_model.sv
`default_nettype none
// Stand-in for the array engine. It answers a read in the same cycle it is asked.
module facd_array_model
  import facd_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Request from the decoder.
  input wire logic i_rd,
  input wire logic [1:0] i_space,
  input wire logic [31:0] i_addr,
  // Answer.
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] idle = 8'h00;
  // The idle value moves every cycle, so a stale sample cannot pass for data.
  always @(posedge i_clk) idle <= idle + 8'h37;
  // Data mixes in the space, so a read from the wrong source shows up.
  assign o_data = i_rd ? (i_addr[7:0] ^ {i_space, 6'h15}) : idle;
endmodule : facd_array_model
`default_nettype wire

// file: sim/facd_tb_top.sv
`default_nettype none
module facd_tb_top
  import facd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, cs_n, rx_valid, tx_req, wel, page_512;
  logic [7:0] rx_byte, array_data, tx_byte, prog_data;
  logic tx_valid, len_4b, wel_clear, array_rd, prog_wr, prog_commit, erase_req;
  logic [1:0] array_space, erase_kind, last_kind;
  logic [31:0] array_addr, first_addr, last_addr;
  logic [7:0] last_data;
  int bad_count = 0;
  int tests_run = 0;
  int erase_n, wclr_n, commit_n, wr_n;
  ////////////////////////////////////////////////////////////////////////////
  facd_top facd_top_i (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_CS_N(cs_n),
    .I_RX_VALID(rx_valid), .I_RX_BYTE(rx_byte), .I_TX_REQ(tx_req),
    .O_TX_VALID(tx_valid), .O_TX_BYTE(tx_byte), .I_WEL(wel), .I_PAGE_512(page_512),
    .O_ADDR_LEN_4B(len_4b), .O_WEL_CLEAR(wel_clear), .I_ARRAY_DATA(array_data),
    .O_ARRAY_RD(array_rd), .O_ARRAY_SPACE(array_space), .O_ARRAY_ADDR(array_addr),
    .O_PROG_WR(prog_wr), .O_PROG_DATA(prog_data), .O_PROG_COMMIT(prog_commit),
    .O_ERASE_REQ(erase_req), .O_ERASE_KIND(erase_kind));
  facd_array_model facd_array_model_i (.i_clk(clk), .i_rd(array_rd),
    .i_space(array_space), .i_addr(array_addr), .o_data(array_data));
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulses are tallied on the falling edge, where outputs have settled.
  always @(negedge clk) begin
    if (erase_req === 1'b1) begin
      erase_n++;
      last_kind = erase_kind;
    end
    if (wel_clear === 1'b1) wclr_n++;
    if (prog_commit === 1'b1) commit_n++;
    if (prog_wr === 1'b1) begin
      if (wr_n == 0) first_addr = array_addr;
      last_addr = array_addr;
      last_data = prog_data;
      wr_n++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("Checks: %0d, mismatches: %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // One byte per two cycles, the closest spacing the link allows.
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_byte = b;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte = ~b;
  endtask : put
  // Opens a frame and sends opcode and address, most significant byte first.
  task automatic head(input logic [7:0] op, input int nadr, input logic [31:0] a);
    @(negedge clk);
    cs_n = 1'b0;
    erase_n = 0;
    wclr_n = 0;
    commit_n = 0;
    wr_n = 0;
    put(op);
    for (int i = nadr - 1; i >= 0; i--) put(a[8*i+:8]);
  endtask : head
  task automatic finish_frame;
    @(negedge clk);
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : finish_frame
  // Reads two bytes; the second proves the address steps on its own.
  task automatic rd(input logic [7:0] op, input int nadr, input logic mode,
                    input logic [31:0] a, input logic [1:0] sp);
    logic [31:0] ea;
    ea = (nadr == 3) ? {8'h00, a[23:0]} : a;
    head(op, nadr, a);
    if (mode) put(8'h3c);
    repeat (2) @(negedge clk);
    chk(array_space, sp);
    for (int k = 0; k < 2; k++) begin
      chk(array_addr, ea + k);
      tx_req = 1'b1;
      #1;
      chk(array_rd, 1'b1);
      @(negedge clk);
      tx_req = 1'b0;
      chk(tx_valid, 1'b1);
      chk(tx_byte, (ea[7:0] + k[7:0]) ^ {sp, 6'h15});
      @(negedge clk);
    end
    finish_frame;
  endtask : rd
  task automatic ers(input logic [7:0] op, input int nadr, input logic w,
                     input logic [1:0] kind);
    wel = w;
    head(op, nadr, 32'h0104_2000);
    finish_frame;
    chk(erase_n, w);
    chk(wclr_n, w);
    if (w) chk(last_kind, kind);
  endtask : ers
  // Sends two bytes past the page so the overflow must be dropped.
  task automatic prg(input logic [7:0] op, input int nadr, input logic w, input logic p);
    int n;
    logic [31:0] base;
    n = p ? 512 : 256;
    base = (nadr == 3) ? 32'h0003_0400 : 32'h0203_0400;
    wel = w;
    page_512 = p;
    head(op, nadr, 32'h0203_0400);
    for (int i = 0; i < n + 2; i++) put(i[7:0] ^ 8'h5a);
    finish_frame;
    chk(wr_n, w ? n : 0);
    chk(commit_n, w);
    chk(wclr_n, w);
    if (w) begin
      chk(first_addr, base);
      chk(last_addr, base + n - 1);
      chk(last_data, 8'ha5);
    end
  endtask : prg
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: three-byte mode first, then four-byte mode, then back.
  initial begin
    {rst_n, rx_valid, tx_req, wel, page_512} = 5'h00;
    cs_n = 1'b1;
    rx_byte = 8'h00;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(len_4b, 1'b0);
    rd(8'h03, 3, 1'b0, 32'h0012_34fe, SPACE_ARRAY);
    rd(8'h13, 4, 1'b0, 32'h8102_0304, SPACE_ARRAY);
    rd(8'h0b, 3, 1'b0, 32'h0045_6710, SPACE_ARRAY);
    rd(8'hd0, 3, 1'b0, 32'h0004_0000, SPACE_ERASE_OUTCOME);
    rd(8'h5d, 3, 1'b0, 32'h0008_0001, SPACE_WEAR_COUNT);
    ers(8'h20, 3, 1'b1, ERASE_SMALL);
    ers(8'h20, 3, 1'b0, ERASE_SMALL);
    ers(8'hd8, 3, 1'b1, ERASE_LARGE);
    ers(8'h60, 0, 1'b1, ERASE_CHIP);
    ers(8'hc7, 0, 1'b1, ERASE_CHIP);
    ers(8'hc7, 0, 1'b0, ERASE_CHIP);
    prg(8'h02, 3, 1'b1, 1'b0);
    prg(8'h02, 3, 1'b0, 1'b0);
    chk(len_4b, 1'b0);
    head(8'hb7, 0, 32'h0);
    finish_frame;
    chk(len_4b, 1'b1);
    rd(8'h0b, 4, 1'b0, 32'h9a00_0020, SPACE_ARRAY);
    rd(8'h0c, 4, 1'b1, 32'h7701_00f0, SPACE_ARRAY);
    rd(8'h03, 4, 1'b0, 32'h4400_0081, SPACE_ARRAY);
    ers(8'h21, 4, 1'b1, ERASE_SMALL);
    ers(8'hdc, 4, 1'b1, ERASE_LARGE);
    ers(8'hd8, 4, 1'b1, ERASE_LARGE);
    prg(8'h12, 4, 1'b1, 1'b1);
    head(8'hb8, 0, 32'h0);
    finish_frame;
    chk(len_4b, 1'b0);
    rd(8'h13, 4, 1'b0, 32'hc300_0042, SPACE_ARRAY);
    conclude;
  end
  // Watchdog: the whole sequence needs well under 20 us.
  initial begin
    #100000;
    bad_count++;
    conclude;
  end
endmodule : facd_tb_top
`default_nettype wire

// file: verilog/facd_addr_collect.sv
`default_nettype none
module facd_addr_collect
  import facd_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Decoder side.
  facd_addr_if.collector ac
);
  logic [2:0] count;
  logic [2:0] next_count;
  logic [31:0] addr;
  logic [31:0] next_addr;
  logic [2:0] need;

  // Bytes arrive most significant first, so each one shifts in at the bottom.
  always_comb begin
    need = ac.four_byte ? ADDR_BYTES_LONG : ADDR_BYTES_SHORT;
    next_count = count;
    next_addr = addr;
    if (ac.clear) begin
      next_count = 3'h0;
      next_addr = 32'h0;
    end else if (ac.shift && count != need) begin
      next_count = count + 3'h1;
      next_addr = {addr[23:0], ac.byte_in};
    end
  end

  // State registers.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= 3'h0;
      addr <= 32'h0;
    end else begin
      count <= next_count;
      addr <= next_addr;
    end
  end

  assign ac.done = (count == need);
  assign ac.addr = addr;
endmodule : facd_addr_collect
`default_nettype wire

// file: verilog/facd_addr_if.sv
`default_nettype none
// Carries address bytes from the decoder into the address collector.
interface facd_addr_if;
  logic clear;
  logic shift;
  logic [7:0] byte_in;
  logic four_byte;
  logic done;
  logic [31:0] addr;
  modport decoder (output clear, output shift, output byte_in, output four_byte,
                   input done, input addr);
  modport collector (input clear, input shift, input byte_in, input four_byte,
                     output done, output addr);
endinterface : facd_addr_if
`default_nettype wire

// file: verilog/facd_pkg.sv
// What this block does
// - Opcode 03 takes current-length address, 13 takes four bytes, then streams array bytes.
// - Opcode 0B takes current-length address; 0C takes four bytes plus one mode byte.
// - Opcodes 02/12 program up to 256 or 512 data bytes per transaction.
// - Opcodes 20/21 erase the addressed 4KB sector to all ones.
// - Opcodes D8/DC erase the addressed 256KB sector to all ones.
// - Opcodes 60 or C7, without address, erase the whole array.
// - Opcode D0 plus address reports whether that sector's last erase succeeded.
// - Opcode 5D plus address returns the erase count of that sector.
// - Opcode B7 selects four-byte addresses, B8 selects three-byte addresses.
`default_nettype none
package facd_pkg;
  // Opcodes.
  localparam logic [7:0] OP_NORMAL_READ_VAR = 8'h03;
  localparam logic [7:0] OP_NORMAL_READ_4B = 8'h13;
  localparam logic [7:0] OP_FAST_READ_VAR = 8'h0b;
  localparam logic [7:0] OP_FAST_READ_4B = 8'h0c;
  localparam logic [7:0] OP_PROGRAM_VAR = 8'h02;
  localparam logic [7:0] OP_PROGRAM_4B = 8'h12;
  localparam logic [7:0] OP_SMALL_ERASE_VAR = 8'h20;
  localparam logic [7:0] OP_SMALL_ERASE_4B = 8'h21;
  localparam logic [7:0] OP_LARGE_ERASE_VAR = 8'hd8;
  localparam logic [7:0] OP_LARGE_ERASE_4B = 8'hdc;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_ERASE_OUTCOME = 8'hd0;
  localparam logic [7:0] OP_WEAR_COUNT = 8'h5d;
  localparam logic [7:0] OP_ADDR_LEN_FOUR = 8'hb7;
  localparam logic [7:0] OP_ADDR_LEN_THREE = 8'hb8;
  // Address lengths in bytes.
  localparam logic [2:0] ADDR_BYTES_SHORT = 3'h3;
  localparam logic [2:0] ADDR_BYTES_LONG = 3'h4;
  // Page buffer sizes in bytes.
  localparam logic [9:0] PAGE_BYTES_SMALL = 10'h100;
  localparam logic [9:0] PAGE_BYTES_LARGE = 10'h200;
  // Address length after reset: three-byte addressing.
  localparam logic ADDR_LEN_RESET = 1'b0;
  // Source selected for a read stream.
  localparam logic [1:0] SPACE_ARRAY = 2'h0;
  localparam logic [1:0] SPACE_ERASE_OUTCOME = 2'h1;
  localparam logic [1:0] SPACE_WEAR_COUNT = 2'h2;
  // Erase kinds.
  localparam logic [1:0] ERASE_SMALL = 2'h0;
  localparam logic [1:0] ERASE_LARGE = 2'h1;
  localparam logic [1:0] ERASE_CHIP = 2'h2;
  // Serial clock ceiling for normal reads, MHz; enforced by the host's clock choice.
  localparam int NORMAL_READ_MAX_MHZ = 50;
  // Decoder states.
  typedef enum logic [5:0] {
    ST_OPCODE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_MODE = 6'b000100,
    ST_DATA_OUT = 6'b001000,
    ST_DATA_IN = 6'b010000,
    ST_WAIT_END = 6'b100000
  } facd_state_e;
endpackage : facd_pkg
`default_nettype wire

// file: verilog/facd_top.sv
`default_nettype none
module facd_top
  import facd_pkg::*;
(
  // Clock and reset.
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  // Deserialised link.
  input wire logic I_CS_N,
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_BYTE,
  input wire logic I_TX_REQ,
  output logic O_TX_VALID,
  output logic [7:0] O_TX_BYTE,
  // Device status and configuration.
  input wire logic I_WEL,
  input wire logic I_PAGE_512,
  output logic O_ADDR_LEN_4B,
  output logic O_WEL_CLEAR,
  // Array engine.
  input wire logic [7:0] I_ARRAY_DATA,
  output logic O_ARRAY_RD,
  output logic [1:0] O_ARRAY_SPACE,
  output logic [31:0] O_ARRAY_ADDR,
  output logic O_PROG_WR,
  output logic [7:0] O_PROG_DATA,
  output logic O_PROG_COMMIT,
  output logic O_ERASE_REQ,
  output logic [1:0] O_ERASE_KIND
);
  facd_addr_if ac ();
  facd_state_e state, next_state;
  logic [7:0] opcode, next_opcode;
  logic addr_len, next_addr_len;
  logic [31:0] array_addr, next_array_addr;
  logic [1:0] space, next_space;
  logic [9:0] count, next_count;
  logic tx_valid, next_tx_valid;
  logic [7:0] tx_byte, next_tx_byte;
  logic prog_wr, next_prog_wr;
  logic [7:0] prog_data, next_prog_data;
  logic prog_commit, next_prog_commit;
  logic erase_req, next_erase_req;
  logic [1:0] erase_kind, next_erase_kind;
  logic wel_clear, next_wel_clear;
  logic four_byte, next_four_byte;
  logic array_rd;
  logic [9:0] page_limit;

  facd_addr_collect u_addr (
    .i_clk(I_SYS_CLK),
    .i_reset_n(I_RESET_N),
    .ac(ac)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode. A frame ends when chip select rises; commands that change state
  // act only then, so a frame cut short never erases or programs.
  always_comb begin
    next_state = state;
    next_opcode = opcode;
    next_addr_len = addr_len;
    next_array_addr = array_addr;
    next_space = space;
    next_count = count;
    next_tx_valid = 1'b0;
    next_tx_byte = tx_byte;
    next_prog_wr = 1'b0;
    next_prog_data = prog_data;
    next_prog_commit = 1'b0;
    next_erase_req = 1'b0;
    next_erase_kind = erase_kind;
    next_wel_clear = 1'b0;
    next_four_byte = four_byte;
    page_limit = I_PAGE_512 ? PAGE_BYTES_LARGE : PAGE_BYTES_SMALL;
    array_rd = (state == ST_DATA_OUT) && I_TX_REQ && !I_CS_N;
    ac.clear = 1'b0;
    ac.shift = 1'b0;
    ac.byte_in = I_RX_BYTE;
    if (I_CS_N) begin
      if (state == ST_WAIT_END) begin
        case (opcode)
          OP_ADDR_LEN_FOUR: next_addr_len = 1'b1;
          OP_ADDR_LEN_THREE: next_addr_len = 1'b0;
          OP_SMALL_ERASE_VAR, OP_SMALL_ERASE_4B: begin
            next_erase_req = 1'b1;
            next_erase_kind = ERASE_SMALL;
          end
          OP_LARGE_ERASE_VAR, OP_LARGE_ERASE_4B: begin
            next_erase_req = 1'b1;
            next_erase_kind = ERASE_LARGE;
          end
          OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
            next_erase_req = 1'b1;
            next_erase_kind = ERASE_CHIP;
          end
          default: next_erase_req = 1'b0;
        endcase
        next_wel_clear = next_erase_req;
      end else if (state == ST_DATA_IN && count != 10'h0) begin
        next_prog_commit = 1'b1;
        next_wel_clear = 1'b1;
      end
      next_state = ST_OPCODE;
      ac.clear = 1'b1;
    end else begin
      case (state)
        ST_OPCODE: begin
          if (I_RX_VALID) begin
            next_opcode = I_RX_BYTE;
            next_count = 10'h0;
            next_state = ST_ADDR;
            next_space = SPACE_ARRAY;
            next_four_byte = addr_len;
            case (I_RX_BYTE)
              OP_NORMAL_READ_VAR, OP_FAST_READ_VAR: ;
              OP_NORMAL_READ_4B, OP_FAST_READ_4B: next_four_byte = 1'b1;
              OP_ERASE_OUTCOME: next_space = SPACE_ERASE_OUTCOME;
              OP_WEAR_COUNT: next_space = SPACE_WEAR_COUNT;
              OP_PROGRAM_VAR, OP_SMALL_ERASE_VAR, OP_LARGE_ERASE_VAR: begin
                if (!I_WEL) next_state = ST_OPCODE;
              end
              OP_PROGRAM_4B, OP_SMALL_ERASE_4B, OP_LARGE_ERASE_4B: begin
                next_four_byte = 1'b1;
                if (!I_WEL) next_state = ST_OPCODE;
              end
              OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                next_state = I_WEL ? ST_WAIT_END : ST_OPCODE;
              end
              OP_ADDR_LEN_FOUR, OP_ADDR_LEN_THREE: next_state = ST_WAIT_END;
              default: next_state = ST_OPCODE;
            endcase
            // A refused or unknown opcode waits out the frame with a cleared
            // opcode, so later bytes are never taken for a new command.
            if (next_state == ST_OPCODE) begin
              next_opcode = 8'h00;
              next_state = ST_WAIT_END;
            end
          end
        end
        ST_ADDR: begin
          ac.shift = I_RX_VALID;
          if (ac.done) begin
            next_array_addr = ac.addr;
            case (opcode)
              OP_FAST_READ_4B: next_state = ST_MODE;
              OP_PROGRAM_VAR, OP_PROGRAM_4B: next_state = ST_DATA_IN;
              OP_SMALL_ERASE_VAR, OP_SMALL_ERASE_4B,
              OP_LARGE_ERASE_VAR, OP_LARGE_ERASE_4B: next_state = ST_WAIT_END;
              default: next_state = ST_DATA_OUT;
            endcase
          end
        end
        ST_MODE: begin
          if (I_RX_VALID) next_state = ST_DATA_OUT;
        end
        ST_DATA_OUT: begin
          // Each byte request fetches one byte; the address then steps on.
          if (array_rd) next_array_addr = array_addr + 32'h1;
          next_tx_valid = array_rd;
        end
        ST_DATA_IN: begin
          // Bytes past the page buffer size are dropped rather than wrapped.
          // A less-than test stays safe if the page size drops mid-frame.
          if (I_RX_VALID && count < page_limit) begin
            next_prog_wr = 1'b1;
            next_prog_data = I_RX_BYTE;
            next_count = count + 10'h1;
            if (count != 10'h0) next_array_addr = array_addr + 32'h1;
          end
        end
        ST_WAIT_END: next_state = ST_WAIT_END;
        default: next_state = ST_OPCODE;
      endcase
    end
    // The array answers in the cycle of the fetch, so the byte is captured then.
    if (array_rd) next_tx_byte = I_ARRAY_DATA;
    // The registered width keeps the collector off this process's own results.
    ac.four_byte = four_byte;
  end

  // The fetch strobe leaves in the cycle the serialiser asks.
  always_comb begin
    O_ARRAY_RD = array_rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers.
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= ST_OPCODE;
      opcode <= 8'h00;
      addr_len <= ADDR_LEN_RESET;
      array_addr <= 32'h0;
      space <= SPACE_ARRAY;
      count <= 10'h0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      prog_wr <= 1'b0;
      prog_data <= 8'h00;
      prog_commit <= 1'b0;
      erase_req <= 1'b0;
      erase_kind <= ERASE_SMALL;
      wel_clear <= 1'b0;
      four_byte <= 1'b0;
    end else begin
      state <= next_state;
      opcode <= next_opcode;
      addr_len <= next_addr_len;
      array_addr <= next_array_addr;
      space <= next_space;
      count <= next_count;
      tx_valid <= next_tx_valid;
      tx_byte <= next_tx_byte;
      prog_wr <= next_prog_wr;
      prog_data <= next_prog_data;
      prog_commit <= next_prog_commit;
      erase_req <= next_erase_req;
      erase_kind <= next_erase_kind;
      wel_clear <= next_wel_clear;
      four_byte <= next_four_byte;
    end
  end

  assign O_TX_VALID = tx_valid;
  assign O_TX_BYTE = tx_byte;
  assign O_ADDR_LEN_4B = addr_len;
  assign O_WEL_CLEAR = wel_clear;
  assign O_ARRAY_SPACE = space;
  assign O_ARRAY_ADDR = array_addr;
  assign O_PROG_WR = prog_wr;
  assign O_PROG_DATA = prog_data;
  assign O_PROG_COMMIT = prog_commit;
  assign O_ERASE_REQ = erase_req;
  assign O_ERASE_KIND = erase_kind;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_NORMAL_READ_4B: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    state == ST_OPCODE && !I_CS_N && I_RX_VALID && I_RX_BYTE == OP_NORMAL_READ_4B
    |=> four_byte && state == ST_ADDR)
    else $error("Opcode 13 did not force a four-byte address.");
  AST_FAST_MODE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    state == ST_ADDR && !I_CS_N && ac.done && opcode == OP_FAST_READ_4B |=> state == ST_MODE)
    else $error("Opcode 0C did not expect a mode byte.");
  AST_PAGE_LIMIT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    !I_PAGE_512 && count <= PAGE_BYTES_SMALL |=> count <= PAGE_BYTES_SMALL)
    else $error("Program byte count passed the small page size.");
  AST_PAGE_LARGE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    count <= PAGE_BYTES_LARGE)
    else $error("Program byte count passed the large page size.");
  AST_SMALL_ERASE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    state == ST_WAIT_END && I_CS_N && opcode == OP_SMALL_ERASE_4B
    |=> erase_req && erase_kind == ERASE_SMALL ##1 !erase_req)
    else $error("Opcode 21 did not raise one small erase pulse.");
  AST_LARGE_ERASE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    state == ST_WAIT_END && I_CS_N && opcode == OP_LARGE_ERASE_VAR
    |=> erase_req && erase_kind == ERASE_LARGE)
    else $error("Opcode D8 did not raise a large erase.");
  AST_CHIP_ERASE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    erase_req && erase_kind == ERASE_CHIP |-> $past(opcode) == OP_CHIP_ERASE_A
    || $past(opcode) == OP_CHIP_ERASE_B)
    else $error("Chip erase raised by a wrong opcode.");
  AST_OUTCOME_SPACE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    O_ARRAY_RD && opcode == OP_ERASE_OUTCOME |-> space == SPACE_ERASE_OUTCOME)
    else $error("Erase outcome query read the wrong source.");
  AST_WEAR_SPACE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    O_ARRAY_RD && opcode == OP_WEAR_COUNT |-> space == SPACE_WEAR_COUNT)
    else $error("Wear count query read the wrong source.");
  AST_ADDR_LEN: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    state == ST_WAIT_END && I_CS_N && opcode == OP_ADDR_LEN_FOUR |=> addr_len)
    else $error("Opcode B7 did not select four-byte addressing.");
  AST_WEL_GATE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    state == ST_OPCODE && !I_CS_N && I_RX_VALID && !I_WEL
    && (I_RX_BYTE == OP_PROGRAM_VAR || I_RX_BYTE == OP_CHIP_ERASE_B)
    |=> state == ST_WAIT_END && opcode == 8'h00)
    else $error("Write command accepted without write enable.");
  COV_READ: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) O_TX_VALID);
  COV_PROGRAM: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) O_PROG_COMMIT);
  COV_ERASE: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    O_ERASE_REQ && O_ERASE_KIND == ERASE_CHIP);
endmodule : facd_top
`default_nettype wire
